//--- verilog/uart_fifo_pkg.sv
package uart_fifo_pkg;
    // -----------------------------------------------------------------
    // control and enhanced feature register layout, FIFO depth and count width
    // -----------------------------------------------------------------
    localparam int RX_TRIG_MSB = 7;
    localparam int RX_TRIG_LSB = 6;
    localparam int TX_TRIG_MSB = 5;
    localparam int TX_TRIG_LSB = 4;
    localparam int DMA_MODE_BIT = 3;
    localparam int TX_FLUSH_BIT = 2;
    localparam int RX_FLUSH_BIT = 1;
    localparam int FIFO_EN_BIT = 0;
    localparam int ENH_ENABLE_BIT = 4;
    localparam logic [7:0] FIFO_CONTROL_RESET = 8'h00;
    localparam logic [7:0] ENH_FEATURE_RESET = 8'h00;
    localparam int FIFO_DEPTH = 64;
    localparam int CNT_W = 7;
    // -----------------------------------------------------------------
    // trigger levels
    // -----------------------------------------------------------------
    localparam logic [6:0] RX_LVL_0 = 7'h08;
    localparam logic [6:0] RX_LVL_1 = 7'h10;
    localparam logic [6:0] RX_LVL_2 = 7'h38;
    localparam logic [6:0] RX_LVL_3 = 7'h3C;
    localparam logic [6:0] TX_LVL_0 = 7'h08;
    localparam logic [6:0] TX_LVL_1 = 7'h10;
    localparam logic [6:0] TX_LVL_2 = 7'h20;
    localparam logic [6:0] TX_LVL_3 = 7'h38;

    typedef struct packed {
        logic [1:0] rxTrig;
        logic [1:0] txTrig;
        logic dmaMode;
        logic fifoEnable;
    } fifo_cfg_t;

    typedef struct packed {
        logic [6:0] count;
        logic full;
        logic empty;
    } fifo_stat_t;
endpackage : uart_fifo_pkg

//--- verilog/fifo_mem.sv
`timescale 1ns/1ps
module fifo_mem
    import uart_fifo_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 64,
    parameter int AW = 6
) (
    // clock
    input wire logic clk,
    // write side
    input wire logic wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [WIDTH-1:0] wrData,
    // read side, registered
    input wire logic [AW-1:0] rdAddr,
    output logic [WIDTH-1:0] rdData
);
    logic [WIDTH-1:0] mem [DEPTH];

    // no reset on the array so it maps to ram
    always_ff @(posedge clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        rdData <= mem[rdAddr];
    end
endmodule : fifo_mem

//--- verilog/skid_buffer.sv
`timescale 1ns/1ps
module skid_buffer
    import uart_fifo_pkg::*;
#(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic flush,
    // input side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // output side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    // two-entry buffer: entry 0 is the head
    logic [WIDTH-1:0] slot0;
    logic [WIDTH-1:0] slot1;
    logic [1:0] fill;
    wire pop = outValid && outReady;
    wire push = inValid && inReady;

    assign inReady = (fill != 2'd2);
    assign outValid = (fill != 2'd0);
    assign outData = slot0;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fill <= 2'd0;
            slot0 <= '0;
            slot1 <= '0;
        end else if (flush) begin
            fill <= 2'd0;
        end else begin
            fill <= fill + {1'b0, push} - {1'b0, pop};
            if (pop) begin
                slot0 <= (fill == 2'd2) ? slot1 : inData;
            end else if (push && fill == 2'd0) begin
                slot0 <= inData;
            end
            if (push && ((fill == 2'd1 && !pop) || fill == 2'd2)) begin
                slot1 <= inData;
            end
        end
    end
endmodule : skid_buffer

//--- verilog/uart_fifo_control.sv
`timescale 1ns/1ps
module uart_fifo_control
    import uart_fifo_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // host register writes
    input wire logic ctrlWrite,
    input wire logic [7:0] ctrlData,
    input wire logic enhWrite,
    input wire logic [7:0] enhData,
    // host reads of the receive FIFO
    input wire logic rxRead,
    output logic [7:0] rxReadData,
    output logic rxDataValid,
    // receive shift register side
    input wire logic rxPushValid,
    input wire logic [7:0] rxPushData,
    // host writes into transmit FIFO
    input wire logic txWrite,
    input wire logic [7:0] txWriteData,
    output logic txWriteReady,
    // transmit shift register side
    output logic txPopValid,
    input wire logic txPopReady,
    output logic [7:0] txPopData,
    // status and configuration
    output fifo_cfg_t cfg,
    output fifo_stat_t rxStat,
    output fifo_stat_t txStat,
    output logic enhancedEnable,
    output logic rxTrigger,
    output logic txTrigger,
    output logic rxOverrun
);
    localparam int AW = $clog2(DEPTH);

    // -----------------------------------------------------------------
    // control register
    // -----------------------------------------------------------------
    // the control register has no read port; its fields are only exported on cfg
    logic [7:0] enhFeature;
    logic [1:0] rxTrigSel;
    logic [1:0] txTrigSel;
    logic dmaMode;
    logic fifoEnable;
    logic txFlushPend;
    logic rxFlushPend;

    assign enhancedEnable = enhFeature[ENH_ENABLE_BIT];
    wire txTrigWrite = ctrlWrite && enhancedEnable;
    wire txFlushReq = ctrlWrite && ctrlData[TX_FLUSH_BIT];
    wire rxFlushReq = ctrlWrite && ctrlData[RX_FLUSH_BIT];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            enhFeature <= ENH_FEATURE_RESET;
        end else if (enhWrite) begin
            enhFeature <= enhData;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rxTrigSel <= FIFO_CONTROL_RESET[RX_TRIG_MSB:RX_TRIG_LSB];
            txTrigSel <= FIFO_CONTROL_RESET[TX_TRIG_MSB:TX_TRIG_LSB];
            dmaMode <= FIFO_CONTROL_RESET[DMA_MODE_BIT];
            fifoEnable <= FIFO_CONTROL_RESET[FIFO_EN_BIT];
        end else if (ctrlWrite) begin
            rxTrigSel <= ctrlData[RX_TRIG_MSB:RX_TRIG_LSB];
            dmaMode <= ctrlData[DMA_MODE_BIT];
            fifoEnable <= ctrlData[FIFO_EN_BIT];
            if (txTrigWrite) begin
                txTrigSel <= ctrlData[TX_TRIG_MSB:TX_TRIG_LSB];
            end
        end
    end

    // flush bits live one cycle: set by the write, cleared once the pointers reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            txFlushPend <= 1'b0;
            rxFlushPend <= 1'b0;
        end else begin
            txFlushPend <= txFlushReq;
            rxFlushPend <= rxFlushReq;
        end
    end

    assign cfg = '{rxTrig: rxTrigSel, txTrig: txTrigSel, dmaMode: dmaMode, fifoEnable: fifoEnable};

    // -----------------------------------------------------------------
    // trigger decode
    // -----------------------------------------------------------------
    wire [6:0] rxLevel = (rxTrigSel == 2'b00) ? RX_LVL_0 :
                         (rxTrigSel == 2'b01) ? RX_LVL_1 :
                         (rxTrigSel == 2'b10) ? RX_LVL_2 : RX_LVL_3;
    wire [6:0] txLevel = (txTrigSel == 2'b00) ? TX_LVL_0 :
                         (txTrigSel == 2'b01) ? TX_LVL_1 :
                         (txTrigSel == 2'b10) ? TX_LVL_2 : TX_LVL_3;

    // -----------------------------------------------------------------
    // receive FIFO
    // -----------------------------------------------------------------
    logic [AW-1:0] rxWrPtr;
    logic [AW-1:0] rxRdPtr;
    logic [CNT_W-1:0] rxCount;
    logic [CNT_W-1:0] rxMemCount;
    logic [7:0] rxMemData;
    logic rxMemValid;
    logic rxBufReady;
    logic rxMemTake;
    wire [CNT_W-1:0] depthCnt = CNT_W'(DEPTH);
    // rxCount covers memory, the read in flight and the output buffer, so the
    // depth limit and the trigger see every byte the host can still read
    wire rxFull = fifoEnable ? (rxCount == depthCnt) : 1'b0;
    wire rxEmpty = (rxCount == '0);
    wire rxMemHas = (rxMemCount != '0);
    // the shift register is outside; a flush clears pointers, counts and the output buffer
    wire rxFlush = rxFlushPend;
    // disabled: every char goes to entry zero and overwrites
    wire rxOverwrite = rxPushValid && !fifoEnable;
    wire rxWrEn = rxPushValid && (!fifoEnable || !rxFull);
    wire rxHostPop = rxDataValid && rxRead;
    wire [AW-1:0] rxWrAddr = fifoEnable ? rxWrPtr : '0;
    wire [AW-1:0] rxRdAddr = fifoEnable ? rxRdPtr : '0;
    // one memory read in flight at a time, so the buffer can never overfill
    wire rxPopMem = rxMemHas && !rxMemValid && rxBufReady && !rxFlush && !rxOverwrite;
    // an overwrite drops the older character wherever it still waits
    wire rxBufFlush = rxFlush || rxOverwrite;
    wire [CNT_W-1:0] rxMemInc = rxMemCount + CNT_W'(rxWrEn) - CNT_W'(rxPopMem);
    wire [CNT_W-1:0] rxCntInc = rxCount + CNT_W'(rxWrEn) - CNT_W'(rxHostPop);
    wire [CNT_W-1:0] next_rxMemCount = fifoEnable ? rxMemInc :
                                       (rxWrEn ? CNT_W'(1) : (rxPopMem ? '0 : rxMemCount));
    wire [CNT_W-1:0] next_rxCount = fifoEnable ? rxCntInc :
                                    (rxWrEn ? CNT_W'(1) : (rxHostPop ? '0 : rxCount));

    fifo_mem #(.WIDTH(8), .DEPTH(DEPTH), .AW(AW)) rx_mem (
        .clk(clk),
        .wrEn(rxWrEn),
        .wrAddr(rxWrAddr),
        .wrData(rxPushData),
        .rdAddr(rxRdAddr),
        .rdData(rxMemData)
    );

    // pointers stay parked at entry zero while the FIFO is off
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rxWrPtr <= '0;
            rxRdPtr <= '0;
        end else if (rxFlush || !fifoEnable) begin
            rxWrPtr <= '0;
            rxRdPtr <= '0;
        end else begin
            if (rxWrEn) rxWrPtr <= rxWrPtr + AW'(1);
            if (rxPopMem) rxRdPtr <= rxRdPtr + AW'(1);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rxCount <= '0;
            rxMemCount <= '0;
        end else if (rxFlush) begin
            rxCount <= '0;
            rxMemCount <= '0;
        end else begin
            rxCount <= next_rxCount;
            rxMemCount <= next_rxMemCount;
        end
    end

    // overrun is judged in the flush cycle too, since that push is dropped as well
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rxMemTake <= 1'b0;
            rxOverrun <= 1'b0;
        end else begin
            rxMemTake <= rxPopMem;
            rxOverrun <= rxPushValid && fifoEnable && rxFull;
        end
    end
    assign rxMemValid = rxMemTake;

    skid_buffer #(.WIDTH(8)) rx_buf (
        .clk(clk),
        .rst(rst),
        .flush(rxBufFlush),
        .inValid(rxMemTake),
        .inReady(rxBufReady),
        .inData(rxMemData),
        .outValid(rxDataValid),
        .outReady(rxRead),
        .outData(rxReadData)
    );

    assign rxStat = '{count: rxCount, full: rxFull, empty: rxEmpty};
    assign rxTrigger = fifoEnable ? (rxCount >= rxLevel) : !rxEmpty;

    // -----------------------------------------------------------------
    // transmit FIFO
    // -----------------------------------------------------------------
    logic [AW-1:0] txWrPtr;
    logic [AW-1:0] txRdPtr;
    logic [CNT_W-1:0] txCount;
    logic [CNT_W-1:0] txMemCount;
    logic [7:0] txMemData;
    logic txMemTake;
    logic txBufReady;
    // txCount holds every byte not yet taken by the shift register side
    wire txFull = (txCount == depthCnt);
    wire txEmpty = (txCount == '0);
    wire txMemHas = (txMemCount != '0);
    wire txTaken = txPopValid && txPopReady;
    // with the FIFO off it still stores bytes; only one slot is offered
    wire [CNT_W-1:0] txLimit = fifoEnable ? depthCnt : CNT_W'(1);
    // writes are refused in the flush cycle so no byte lands behind cleared pointers
    assign txWriteReady = (txCount < txLimit) && !txFlushPend;
    wire txWrEn = txWrite && txWriteReady;
    wire txPopMem = txMemHas && !txMemTake && txBufReady && !txFlushPend;
    wire [CNT_W-1:0] next_txMemCount = txMemCount + CNT_W'(txWrEn) - CNT_W'(txPopMem);
    wire [CNT_W-1:0] next_txCount = txCount + CNT_W'(txWrEn) - CNT_W'(txTaken);

    fifo_mem #(.WIDTH(8), .DEPTH(DEPTH), .AW(AW)) tx_mem (
        .clk(clk),
        .wrEn(txWrEn),
        .wrAddr(txWrPtr),
        .wrData(txWriteData),
        .rdAddr(txRdPtr),
        .rdData(txMemData)
    );

    // pointers and counts share the flush so they can never disagree
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            txWrPtr <= '0;
            txRdPtr <= '0;
        end else if (txFlushPend) begin
            txWrPtr <= '0;
            txRdPtr <= '0;
        end else begin
            if (txWrEn) txWrPtr <= txWrPtr + AW'(1);
            if (txPopMem) txRdPtr <= txRdPtr + AW'(1);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            txCount <= '0;
            txMemCount <= '0;
        end else if (txFlushPend) begin
            txCount <= '0;
            txMemCount <= '0;
        end else begin
            txCount <= next_txCount;
            txMemCount <= next_txMemCount;
        end
    end

    // a read in flight during a flush is cancelled, never handed on
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            txMemTake <= 1'b0;
        end else begin
            txMemTake <= txPopMem;
        end
    end

    // a byte already handed to the shift register is gone from here,
    // so flushing cannot disturb the character on the wire
    skid_buffer #(.WIDTH(8)) tx_buf (
        .clk(clk),
        .rst(rst),
        .flush(txFlushPend),
        .inValid(txMemTake),
        .inReady(txBufReady),
        .inData(txMemData),
        .outValid(txPopValid),
        .outReady(txPopReady),
        .outData(txPopData)
    );

    assign txStat = '{count: txCount, full: txFull, empty: txEmpty};
    wire [CNT_W-1:0] txFree = depthCnt - txCount;
    assign txTrigger = fifoEnable ? (txFree >= txLevel) : txEmpty;
endmodule : uart_fifo_control

//--- testbench/uart_fifo_control_assertions.sv
`timescale 1ns/1ps
module uart_fifo_control_checker
    import uart_fifo_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // watched ports
    input wire logic ctrlWrite,
    input wire logic [7:0] ctrlData,
    input wire logic rxRead,
    input wire logic rxPushValid,
    input wire logic txWriteReady,
    input wire fifo_cfg_t cfg,
    input wire fifo_stat_t rxStat,
    input wire fifo_stat_t txStat,
    input wire logic enhancedEnable,
    input wire logic rxTrigger,
    input wire logic txTrigger,
    input wire logic rxOverrun
);
    logic [6:0] rxLvl;
    logic [6:0] txLvl;
    logic [7:0] txFree;
    assign rxLvl = cfg.rxTrig[1] ? (cfg.rxTrig[0] ? RX_LVL_3 : RX_LVL_2) : (cfg.rxTrig[0] ? RX_LVL_1 : RX_LVL_0);
    assign txLvl = cfg.txTrig[1] ? (cfg.txTrig[0] ? TX_LVL_3 : TX_LVL_2) : (cfg.txTrig[0] ? TX_LVL_1 : TX_LVL_0);
    assign txFree = 8'(DEPTH) - {1'b0, txStat.count};
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ----
    // properties
    // ----
    property p_rx_trig; cfg.fifoEnable |-> rxTrigger == (rxStat.count >= rxLvl); endproperty
    a_rx_trig: assert property (p_rx_trig) else $error("rx trigger level wrong");
    property p_tx_trig; cfg.fifoEnable |-> txTrigger == (txFree >= {1'b0, txLvl}); endproperty
    a_tx_trig: assert property (p_tx_trig) else $error("tx trigger level wrong");
    property p_tx_lock; ctrlWrite && !enhancedEnable |=> $stable(cfg.txTrig); endproperty
    a_tx_lock: assert property (p_tx_lock) else $error("locked tx trigger changed");
    property p_dma; ctrlWrite |=> cfg.dmaMode == $past(ctrlData[3]); endproperty
    a_dma: assert property (p_dma) else $error("dma mode not taken");
    property p_fields; ctrlWrite |=> {cfg.rxTrig, cfg.fifoEnable} == $past({ctrlData[7:6], ctrlData[0]}); endproperty
    a_fields: assert property (p_fields) else $error("control fields not taken");
    property p_tx_flush; ctrlWrite && ctrlData[2] |=> ##1 txStat.empty && txStat.count == 7'h00; endproperty
    a_tx_flush: assert property (p_tx_flush) else $error("tx flush left data");
    property p_rx_flush; (ctrlWrite && ctrlData[1]) ##1 !rxPushValid |=> rxStat.empty; endproperty
    a_rx_flush: assert property (p_rx_flush) else $error("rx flush left data");
    property p_overrun; cfg.fifoEnable && rxStat.full && rxPushValid && !rxRead |=> rxOverrun; endproperty
    a_overrun: assert property (p_overrun) else $error("no overrun on full push");
    property p_tx_full; txStat.full |-> !txWriteReady; endproperty
    a_tx_full: assert property (p_tx_full) else $error("full tx still ready");
    property p_single; !cfg.fifoEnable && rxStat.count == 7'h01 && rxPushValid && !rxRead |=> rxStat.count == 7'h01;
    endproperty
    a_single: assert property (p_single) else $error("disabled rx grew");
    c_full: cover property (rxStat.full && rxPushValid);
    c_flush: cover property (ctrlWrite && ctrlData[2] && !txStat.empty);
    c_single: cover property (!cfg.fifoEnable && rxStat.count == 7'h01 && rxPushValid);
endmodule : uart_fifo_control_checker

bind uart_fifo_control uart_fifo_control_checker #(.DEPTH(DEPTH)) checker_i (.clk(clk), .rst(rst),
    .ctrlWrite(ctrlWrite), .ctrlData(ctrlData), .rxRead(rxRead), .rxPushValid(rxPushValid),
    .txWriteReady(txWriteReady), .cfg(cfg), .rxStat(rxStat), .txStat(txStat), .enhancedEnable(enhancedEnable),
    .rxTrigger(rxTrigger), .txTrigger(txTrigger), .rxOverrun(rxOverrun));

//--- testbench/tx_shift_sink.sv
`timescale 1ns/1ps
module tx_shift_sink (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // stream from the transmit fifo
    input wire logic txPopValid,
    input wire logic [7:0] txPopData,
    output logic txPopReady,
    // stall from bench
    input wire logic stall
);
    logic [7:0] mem [0:255];
    int taken;
    logic slow;
    // ready toggles so the buffer sees both quick and slow takes
    assign txPopReady = !stall && slow;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            taken <= 0;
            slow <= 1'b0;
        end else begin
            slow <= !slow;
            if (txPopValid && txPopReady) begin
                mem[taken[7:0]] <= txPopData;
                taken <= taken + 1;
            end
        end
    end
endmodule : tx_shift_sink

//--- testbench/uart_fifo_control_test.sv
`timescale 1ns/1ps
module uart_fifo_control_test
    import uart_fifo_pkg::*;
();
    logic clk, rst, ctrlWrite, enhWrite, rxRead, rxDataValid, rxPushValid, txWrite, txWriteReady;
    logic txPopValid, txPopReady, enhancedEnable, rxTrigger, txTrigger, rxOverrun, stall, ok;
    logic [7:0] ctrlData, enhData, rxReadData, rxPushData, txWriteData, txPopData, d;
    fifo_cfg_t cfg;
    fifo_stat_t rxStat, txStat;
    int err_total = 0, comparisons = 0, seed = 90, n, k;
    logic [7:0] q[$];
    uart_fifo_control #(.DEPTH(FIFO_DEPTH)) uart_fifo_control_i (.clk(clk), .rst(rst), .ctrlWrite(ctrlWrite),
        .ctrlData(ctrlData), .enhWrite(enhWrite), .enhData(enhData), .rxRead(rxRead), .rxReadData(rxReadData),
        .rxDataValid(rxDataValid), .rxPushValid(rxPushValid), .rxPushData(rxPushData), .txWrite(txWrite),
        .txWriteData(txWriteData), .txWriteReady(txWriteReady), .txPopValid(txPopValid), .txPopReady(txPopReady),
        .txPopData(txPopData), .cfg(cfg), .rxStat(rxStat), .txStat(txStat), .enhancedEnable(enhancedEnable),
        .rxTrigger(rxTrigger), .txTrigger(txTrigger), .rxOverrun(rxOverrun));
    tx_shift_sink tx_shift_sink_i (.clk(clk), .rst(rst), .txPopValid(txPopValid), .txPopData(txPopData),
        .txPopReady(txPopReady), .stall(stall));
    // ----
    // helpers
    // ----
    function automatic int exp_rx(input int c);
        return (c == 0) ? 8 : (c == 1) ? 16 : (c == 2) ? 56 : 60;
    endfunction : exp_rx
    task automatic cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : cmp_byte
    task automatic cmp_flag(input string what, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %b, seen %b", what, exp, got);
        end
    endtask : cmp_flag
    task automatic wr_ctrl(input logic [7:0] v);
        @(negedge clk);
        ctrlData = v;
        ctrlWrite = 1'b1;
        if (v[1]) q.delete();
        @(negedge clk);
        ctrlWrite = 1'b0;
    endtask : wr_ctrl
    task automatic push(input logic [7:0] v);
        @(negedge clk);
        rxPushData = v;
        rxPushValid = 1'b1;
        @(negedge clk);
        rxPushValid = 1'b0;
    endtask : push
    task automatic rd_rx(output logic [7:0] v);
        logic got;
        got = 1'b0;
        v = 8'h00;
        // data is taken while it stands; the read strobe then covers one edge
        for (int i = 0; i < 20 && !got; i++) begin
            @(negedge clk);
            if (rxDataValid === 1'b1) begin
                v = rxReadData;
                got = 1'b1;
                rxRead = 1'b1;
            end
        end
        if (got) begin
            @(negedge clk);
            rxRead = 1'b0;
        end
        cmp_flag("rxDataValid", 1'b1, got);
    endtask : rd_rx
    task automatic tx_put(input logic [7:0] v, output logic acc);
        @(negedge clk);
        acc = (txWriteReady === 1'b1);
        if (acc) begin
            txWriteData = v;
            txWrite = 1'b1;
            @(negedge clk);
            txWrite = 1'b0;
        end
    endtask : tx_put
    task automatic wrap_up;
        $display("comparisons %0d, mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up
    // ----
    // sequence
    // ----
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        // the scenarios need under a thousand cycles; this leaves ample margin
        #200000;
        err_total++;
        wrap_up();
    end
    initial begin
        {rst, stall} = 2'b11;
        {ctrlData, enhData, rxPushData, txWriteData} = 32'h0000_0000;
        {ctrlWrite, enhWrite, rxRead, rxPushValid, txWrite} = 5'h00;
        repeat (5) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        cmp_byte("cfg", 8'h00, {2'b00, cfg});
        cmp_flag("txTrigger", 1'b1, txTrigger);
        wr_ctrl(8'h39);
        cmp_byte("cfg", 8'h03, {2'b00, cfg});
        @(negedge clk);
        enhData = 8'h10;
        enhWrite = 1'b1;
        @(negedge clk);
        enhWrite = 1'b0;
        cmp_flag("enhancedEnable", 1'b1, enhancedEnable);
        for (int c = 0; c < 4; c++) begin
            wr_ctrl({c[1:0], c[1:0], 4'h3});
            cmp_byte("cfg", {2'b00, c[1:0], c[1:0], 2'b01}, {2'b00, cfg});
            for (k = 1; k < exp_rx(c); k++) push(8'($random(seed)));
            repeat (3) @(negedge clk);
            cmp_flag("rxTrigger", 1'b0, rxTrigger);
            push(8'($random(seed)));
            repeat (3) @(negedge clk);
            cmp_flag("rxTrigger", 1'b1, rxTrigger);
        end
        wr_ctrl(8'hF3);
        for (k = 0; k < FIFO_DEPTH + 1; k++) begin
            d = 8'($random(seed));
            push(d);
            cmp_flag("rxOverrun", k == FIFO_DEPTH, rxOverrun);
            if (k < FIFO_DEPTH) q.push_back(d);
        end
        repeat (3) @(negedge clk);
        cmp_flag("rx full", 1'b1, rxStat.full);
        for (k = 0; k < 5; k++) begin
            rd_rx(d);
            cmp_byte("rx data", q.pop_front(), d);
        end
        wr_ctrl(8'hF3);
        repeat (2) @(negedge clk);
        cmp_byte("rx count", 8'h00, {1'b0, rxStat.count});
        push(8'hA5);
        push(8'h5A);
        wr_ctrl(8'hF1);
        repeat (3) @(negedge clk);
        cmp_byte("rx count", 8'h02, {1'b0, rxStat.count});
        n = 0;
        ok = 1'b1;
        for (k = 0; k < 80 && ok; k++) begin
            d = 8'($random(seed));
            tx_put(d, ok);
            if (ok) q.push_back(d);
            if (ok) n++;
        end
        cmp_flag("tx depth", 1'b1, n == FIFO_DEPTH);
        cmp_flag("txTrigger", 1'b0, txTrigger);
        stall = 1'b0;
        for (k = 0; k < 1000 && tx_shift_sink_i.taken < n; k++) @(negedge clk);
        for (k = 0; k < n; k++) cmp_byte("tx data", q[k], tx_shift_sink_i.mem[k]);
        stall = 1'b1;
        for (k = 0; k < 10; k++) tx_put(8'($random(seed)), ok);
        wr_ctrl(8'hF5);
        repeat (2) @(negedge clk);
        cmp_byte("tx count", 8'h00, {1'b0, txStat.count});
        stall = 1'b0;
        repeat (10) @(negedge clk);
        cmp_flag("tx drained", 1'b1, tx_shift_sink_i.taken == n);
        wr_ctrl(8'hF2);
        push(8'h3C);
        push(8'hC3);
        repeat (3) @(negedge clk);
        cmp_byte("rx count", 8'h01, {1'b0, rxStat.count});
        rd_rx(d);
        cmp_byte("rx data", 8'hC3, d);
        wrap_up();
    end
endmodule : uart_fifo_control_test
